// file: bench/vbof_output_formatter_assertions.sv
`include "vbof_params.svh"
`default_nettype none
module vbof_output_formatter_assertions #(
  parameter int SAMPLE_W = 8,
  parameter int TICK_DIV = 200
) (
  input wire logic                                    clock,
  input wire logic                                    reset_n,
  input wire logic [`VBOF_ADDR_W-1:0]                 address,
  input wire logic [`VBOF_DATA_W-1:0]                 write_data,
  input wire logic                                    write_strobe,
  input wire logic                                    read_strobe,
  input wire logic [`VBOF_DATA_W-1:0]                 read_data,
  input wire logic                                    external_pulse,
  input wire logic                                    output_clock,
  input wire logic [`VBOF_BAND_CHANNELS*SAMPLE_W-1:0] first_band_input,
  input wire vbof_pkg::vbof_port_s                    first_output_port,
  input wire vbof_pkg::vbof_port_s                    second_output_port
);
  timeunit 1ns;
  timeprecision 1ps;
  // tick spacing in link cycles for the 25 ns and 30 ns clocks
  localparam int GLO = TICK_DIV * 5 / 6 - 3;
  localparam int GHI = TICK_DIV * 5 / 6 + 3;
  logic [4:0] since;
  logic       tst;
  wire        ctl_wr = write_strobe && address == `VBOF_OFS_CONTROL;
  wire        q_data = since == 5'h1f && !tst;
  wire        q_test = since == 5'h1f && tst;
  wire [15:0] p1_lo = first_output_port.stream[15:0];
  wire [15:0] even1;
  wire [15:0] sign1;
  // settled test selection, long after the last control write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      since <= 5'h0;
      tst   <= 1'b0;
    end else if (ctl_wr) begin
      since <= 5'h0;
      tst   <= write_data[`VBOF_CTL_TEST];
    end else if (since != 5'h1f) begin
      since <= since + 5'h1;
    end
  end
  // upper code bits and sample signs per channel
  for (genvar k = 0; k < 16; k++) begin : g_bit
    assign even1[k] = first_output_port.stream[2*k];
    assign sign1[k] = first_band_input[k*SAMPLE_W+SAMPLE_W-1];
  end
  property p_rd_idle;
    @(posedge clock) disable iff (!reset_n) !$past(read_strobe) |-> read_data == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_tick_pulse;
    @(posedge output_clock) disable iff (!reset_n)
      first_output_port.tick |=> !first_output_port.tick [*8];
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
  property p_tick_both;
    @(posedge output_clock) disable iff (!reset_n)
      first_output_port.tick == second_output_port.tick;
  endproperty
  a_tick_both: assert property (p_tick_both) else $error("port ticks differ");
  property p_tick_gap;
    @(posedge output_clock) disable iff (!reset_n || external_pulse)
      first_output_port.tick |-> ##[GLO:GHI] first_output_port.tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick period wrong");
  property p_sign;
    @(posedge output_clock) disable iff (!reset_n) q_data |-> even1 == ~$past(sign1);
  endproperty
  a_sign: assert property (p_sign) else $error("upper code bit wrong");
  property p_pat_both;
    @(posedge output_clock) disable iff (!reset_n) q_test |->
      second_output_port.stream == {p1_lo, first_output_port.stream[31:16]};
  endproperty
  a_pat_both: assert property (p_pat_both) else $error("pattern ports differ");
  property p_pat_restart;
    @(posedge output_clock) disable iff (!reset_n)
      q_test && $past(first_output_port.tick) |-> p1_lo == 16'h0;
  endproperty
  a_pat_restart: assert property (p_pat_restart) else $error("pattern no restart");
  property p_pat_step;
    @(posedge output_clock) disable iff (!reset_n)
      q_test && !$past(first_output_port.tick) |-> p1_lo == $past(p1_lo) + 16'h1;
  endproperty
  a_pat_step: assert property (p_pat_step) else $error("pattern step wrong");
endmodule
bind vbof_output_formatter vbof_output_formatter_assertions #(
  .SAMPLE_W(SAMPLE_W),
  .TICK_DIV(TICK_DIV)
) u_chk (.clock, .reset_n, .address, .write_data, .write_strobe, .read_strobe,
  .read_data, .external_pulse, .output_clock, .first_band_input, .first_output_port,
  .second_output_port);
`default_nettype wire

// file: bench/vbof_output_formatter_tb.sv
`include "vbof_params.svh"
`default_nettype none
`define CHK(w, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", w, e, g); end end
module vbof_output_formatter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TD = 200;
  localparam logic [7:0] SV [4] = '{8'hc0, 8'hf0, 8'h10, 8'h40};
  logic                 clock = 0;
  logic                 output_clock = 0;
  logic                 reset_n = 0;
  logic [7:0]           address = 8'h00;
  logic [31:0]          write_data = 32'h0;
  logic                 write_strobe = 0;
  logic                 read_strobe = 0;
  logic [31:0]          read_data;
  logic [1:0]           mode_pins = 2'h3;
  logic                 external_pulse = 0;
  logic [255:0]         first_band_input;
  logic [255:0]         second_band_input;
  vbof_pkg::vbof_port_s first_output_port;
  vbof_pkg::vbof_port_s second_output_port;
  logic [31:0]          word1, word2, d;
  int                   ticks, n_mismatch = 0, num_checks = 0;
  always #12.5 clock = ~clock;
  always #15 output_clock = ~output_clock;
  vbof_output_formatter #(.TICK_DIV(TD)) dut (.clock, .reset_n, .address, .write_data,
    .write_strobe, .read_strobe, .read_data, .mode_pins, .external_pulse, .output_clock,
    .first_band_input, .second_band_input, .first_output_port, .second_output_port);
  vbof_recorder rec (.output_clock, .first_output_port, .second_output_port, .word1,
    .word2, .ticks);
  // expected port word: code of channel k in band b, upper bit even
  function automatic logic [31:0] expw(int b, int base);
    logic [1:0] c;
    expw = '0;
    for (int j = 0; j < 16; j++) begin
      c = 2'((base + j + 2 * ((base + j) / 16) + b) % 4);
      expw[2*j] = c[1];
      expw[2*j+1] = c[0];
    end
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    address <= a;
    write_data <= v;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 d = read_data;
  endtask
  task automatic woc(input int n);
    repeat (n) @(posedge output_clock);
    #1;
  endtask
  task automatic wait_tick(input int lim);
    int t;
    t = ticks;
    for (int i = 0; i < lim && ticks == t; i++) woc(1);
    if (ticks == t) begin
      `CHK("tick wait", t + 1, ticks)
      close_out();
    end
  endtask
  task automatic t_regs();
    rd(`VBOF_OFS_CONTROL);
    `CHK("control", 32'h0, d)
    rd(`VBOF_OFS_GAIN_BASE);
    `CHK("gain0", 32'h20, d)
    wr(8'h20, 32'hffffffff);
    rd(8'h20);
    `CHK("unmapped", 32'h0, d)
    $display("t_regs done");
  endtask
  // mode codes 0 to 2 by command, then code 3 from the pins
  task automatic t_mode();
    for (int m = 0; m < 4; m++) begin
      wr(`VBOF_OFS_CONTROL, m < 3 ? 32'(m) : 32'h4);
      woc(12);
      rd(`VBOF_OFS_STATUS);
      `CHK("mode", 2'(m), d[5:4])
      `CHK("port1", expw(0, 0), word1)
      `CHK("port2", (m == 1 || m == 2) ? expw(1, 0) : expw(0, 16), word2)
    end
    $display("t_mode done");
  endtask
  task automatic t_gain();
    wr(`VBOF_OFS_CONTROL, 32'h1);
    wr(`VBOF_OFS_GAIN_BASE + 8'h04, 32'h8);
    wr(`VBOF_OFS_GAIN_BASE + 8'h08, 32'h8);
    rd(`VBOF_OFS_STATUS);
    `CHK("dropped", 1'b1, d[3])
    repeat (20) @(posedge clock);
    wr(`VBOF_OFS_GAIN_BASE + 8'h40, 32'h8);
    wr(`VBOF_OFS_STATUS, 32'h8);
    rd(`VBOF_OFS_STATUS);
    `CHK("drop clear", 1'b0, d[3])
    woc(12);
    `CHK("gain ch1", expw(0, 0) & ~32'h8, word1)
    `CHK("gain ch16", expw(1, 0) & ~32'h2, word2)
    $display("t_gain done");
  endtask
  // period, arming, a late pulse that must be ignored
  task automatic t_tick();
    realtime t1;
    wait_tick(200);
    t1 = $realtime;
    wait_tick(200);
    `CHK("period", 1'b1, $realtime - t1 > TD * 25 - 91 && $realtime - t1 < TD * 25 + 91)
    wr(`VBOF_OFS_CONTROL, 32'h11);
    woc(40);
    rd(`VBOF_OFS_STATUS);
    `CHK("armed", 1'b1, d[1])
    @(posedge clock);
    external_pulse <= 1'b1;
    wait_tick(20);
    t1 = $realtime;
    repeat (8) @(posedge clock);
    external_pulse <= 1'b0;
    rd(`VBOF_OFS_STATUS);
    `CHK("aligned", 1'b1, d[0])
    `CHK("disarmed", 1'b0, d[1])
    woc(60);
    @(posedge clock);
    external_pulse <= 1'b1;
    repeat (24) @(posedge clock);
    external_pulse <= 1'b0;
    wait_tick(200);
    `CHK("held", 1'b1, $realtime - t1 > TD * 25 - 91 && $realtime - t1 < TD * 25 + 91)
    $display("t_tick done");
  endtask
  task automatic t_test();
    wr(`VBOF_OFS_CONTROL, 32'h9);
    woc(30);
    wait_tick(200);
    woc(1);
    `CHK("pattern start", 32'hffff0000, word1)
    woc(5);
    `CHK("pattern step", 32'hfffa0005, word1)
    `CHK("pattern port2", 32'h0005fffa, word2)
    wr(`VBOF_OFS_CONTROL, 32'h1);
    woc(12);
    `CHK("data back", expw(0, 0) & ~32'h8, word1)
    $display("t_test done");
  endtask
  initial begin
    for (int k = 0; k < 32; k++) begin
      first_band_input[k*8+:8] <= SV[(k + 2 * (k / 16)) % 4];
      second_band_input[k*8+:8] <= SV[(k + 2 * (k / 16) + 1) % 4];
    end
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    woc(6);
    t_regs();
    t_mode();
    t_gain();
    t_tick();
    t_test();
    close_out();
  end
endmodule
`default_nettype wire

// file: bench/vbof_recorder.sv
`default_nettype none
module vbof_recorder (
  input  wire logic                 output_clock,
  input  wire vbof_pkg::vbof_port_s first_output_port,
  input  wire vbof_pkg::vbof_port_s second_output_port,
  output var  logic [31:0]          word1,
  output var  logic [31:0]          word2,
  output var  int                   ticks
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ticks = 0;
  // receiver takes every stream on the rising link edge only
  always @(posedge output_clock) begin
    word1 <= first_output_port.stream;
    word2 <= second_output_port.stream;
    ticks <= ticks + int'(first_output_port.tick);
  end
endmodule
`default_nettype wire

// file: hw/vbof_output_formatter.sv
// Overview of operation
// R1 - Mode one sends first band channels 0-15 to the first port and 16-31 to the second.
// R2 - Mode two sends channels 0-15 of the first band to the first port, of the second to the second.
// R3 - Mode three sends all 16 wide channels of each band to its own port at the faster clock; the code handles it exactly as mode two, on the one output clock.
// R4 - Each port carries 16 channels of two bits, each channel on two adjacent bit-streams.
// R5 - Samples are coded offset binary, 00 most negative up to 11 most positive.
// R6 - The upper bit of each code goes on the even stream, the lower bit on the odd stream.
// R7 - A once-per-second tick is made on each port by dividing the sample clock alone.
// R8 - The tick divider is phase aligned to the external pulse one time only.
// R9 - After alignment the tick runs on unchanged without the external pulse.
// R10 - The test pattern restarts at every internal tick.
// R11 - The test pattern advances one word per output clock.
// R12 - The test pattern may replace normal data on both ports and be removed without restart.
// R13 - The mode comes from stored configuration, chosen by header pins or by a command.
// R14 - Once armed, the divider aligns to the first external pulse that follows.
// R15 - Each output channel has its own gain setting written over the control interface.
// R16 - Each channel sample is requantized to two bits against thresholds set by its gain.
// R17 - All streams and the tick change only on the rising edge of the output clock.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`include "vbof_params.svh"
`default_nettype none
module vbof_output_formatter #(
  parameter int  SAMPLE_W = 8,
  parameter int  TICK_DIV = `VBOF_TICK_DIV
) (
  input  wire logic                                   clock,
  input  wire logic                                   reset_n,
  input  wire logic [`VBOF_ADDR_W-1:0]                address,
  input  wire logic [`VBOF_DATA_W-1:0]                write_data,
  input  wire logic                                   write_strobe,
  input  wire logic                                   read_strobe,
  output logic      [`VBOF_DATA_W-1:0]                read_data,
  input  wire logic [1:0]                             mode_pins,
  input  wire logic                                   external_pulse,
  input  wire logic                                   output_clock,
  input  wire logic [`VBOF_BAND_CHANNELS*SAMPLE_W-1:0] first_band_input,
  input  wire logic [`VBOF_BAND_CHANNELS*SAMPLE_W-1:0] second_band_input,
  output vbof_pkg::vbof_port_s                        first_output_port,
  output vbof_pkg::vbof_port_s                        second_output_port
);

  localparam int GW = `VBOF_GAIN_W;
  localparam int QW = SAMPLE_W + GW + 1;

  // two-bit requantizer, offset binary
  function automatic logic [1:0] quantize(input logic [SAMPLE_W-1:0] s,
                                          input logic [GW-1:0] g);
    logic signed [QW-1:0] sx;
    logic signed [QW-1:0] tx;
    sx = QW'($signed(s));
    tx = QW'($signed({1'b0, g}));
    if (sx < -tx)
      quantize = 2'h0;
    else if (sx < QW'(0))
      quantize = 2'h1;
    else if (sx < tx)
      quantize = 2'h2;
    else
      quantize = 2'h3;
  endfunction

  // mode field to enum, reserved code falls back to mode one
  function automatic vbof_pkg::vbof_mode_e to_mode(input logic [1:0] m);
    if (m == 2'h1)
      to_mode = vbof_pkg::VBOF_MODE_TWO;
    else if (m == 2'h2)
      to_mode = vbof_pkg::VBOF_MODE_THREE;
    else
      to_mode = vbof_pkg::VBOF_MODE_ONE;
  endfunction

  // ---------------- sample clock domain ----------------

  logic [1:0]                 ctl_mode;
  logic                       ctl_use_pins;
  logic                       ctl_test;
  logic                       armed;
  logic                       aligned;
  logic                       dropped;
  logic [GW-1:0]              gain_copy [`VBOF_BAND_CHANNELS];
  logic [1:0]                 pins_s1;
  logic [1:0]                 pins_s2;
  logic                       pulse_s1;
  logic                       pulse_s2;
  logic                       pulse_s3;
  logic [31:0]                div_count;
  logic                       tick_toggle;
  logic                       gain_pending;
  vbof_pkg::vbof_xfer_s       gain_hold;
  vbof_pkg::vbof_xfer_s       xfer_hold;
  logic                       xfer_req;
  logic                       ack_s1;
  logic                       ack_s2;
  logic [2:0]                 sent_cfg;
  logic                       ack_toggle;

  // address decode
  wire       hit_control = address == `VBOF_OFS_CONTROL;
  wire       hit_status  = address == `VBOF_OFS_STATUS;
  wire       hit_gain    = address >= `VBOF_OFS_GAIN_BASE && address <= `VBOF_OFS_GAIN_LAST
                           && address[1:0] == 2'h0;
  wire [`VBOF_ADDR_W-1:0]     gain_ofs  = address - `VBOF_OFS_GAIN_BASE;
  wire [`VBOF_GAIN_IDX_W-1:0] gain_idx  = gain_ofs[`VBOF_GAIN_IDX_W+1:2];
  wire       wr_control  = write_strobe && hit_control;
  wire       wr_status   = write_strobe && hit_status;
  wire       wr_gain     = write_strobe && hit_gain;

  // effective mode: header pins or command
  wire [1:0] eff_mode = ctl_use_pins ? pins_s2 : ctl_mode; // R13
  wire [2:0] cfg_now  = {ctl_test, eff_mode};

  // alignment on the first external pulse after arming
  wire       pulse_rise = pulse_s2 && !pulse_s3;
  wire       align_now  = pulse_rise && armed && !aligned; // R8 R14
  wire       div_wrap   = div_count == 32'(TICK_DIV - 1);
  wire       tick_event = div_wrap || align_now; // R7 R9
  wire [31:0] next_div  = tick_event ? 32'h0 : div_count + 32'h1;

  // crossing handshake state
  wire       busy       = xfer_req != ack_s2;
  wire       send_gain  = !busy && gain_pending;
  wire       send_cfg   = !busy && !gain_pending && cfg_now != sent_cfg;
  wire       gain_take  = wr_gain && !gain_pending;

  // status word and read mux
  wire [`VBOF_DATA_W-1:0] status_word =
    `VBOF_DATA_W'({eff_mode, dropped, busy, armed, aligned});
  wire [`VBOF_DATA_W-1:0] control_word =
    `VBOF_DATA_W'({armed, ctl_test, ctl_use_pins, ctl_mode});
  wire [`VBOF_DATA_W-1:0] read_mux =
    hit_control ? control_word :
    hit_status  ? status_word  :
    hit_gain    ? `VBOF_DATA_W'(gain_copy[gain_idx]) : `VBOF_DATA_W'(0);

  // mode pin synchroniser
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pins_s1 <= 2'h0;
      pins_s2 <= 2'h0;
    end else begin
      pins_s1 <= mode_pins;
      pins_s2 <= pins_s1;
    end
  end

  // external pulse synchroniser and edge history
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pulse_s1 <= 1'b0;
      pulse_s2 <= 1'b0;
      pulse_s3 <= 1'b0;
    end else begin
      pulse_s1 <= external_pulse;
      pulse_s2 <= pulse_s1;
      pulse_s3 <= pulse_s2;
    end
  end

  // control register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctl_mode     <= `VBOF_RST_MODE;
      ctl_use_pins <= 1'b0;
      ctl_test     <= 1'b0;
    end else if (wr_control) begin
      ctl_mode     <= write_data[`VBOF_CTL_MODE_MSB:`VBOF_CTL_MODE_LSB]; // R13
      ctl_use_pins <= write_data[`VBOF_CTL_USE_PINS];
      ctl_test     <= write_data[`VBOF_CTL_TEST]; // R12
    end
  end

  // arm and one-time alignment
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      armed   <= 1'b0;
      aligned <= 1'b0;
    end else if (align_now) begin
      armed   <= 1'b0;
      aligned <= 1'b1; // R8
    end else if (wr_control && write_data[`VBOF_CTL_ARM] && !aligned) begin
      armed   <= 1'b1; // R14
    end
  end

  // once-per-second divider
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      div_count <= 32'h0;
    else
      div_count <= next_div; // R7
  end

  // tick event crosses as a toggle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      tick_toggle <= 1'b0;
    else
      tick_toggle <= tick_toggle ^ tick_event;
  end

  // dropped gain write flag, set wins over clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      dropped <= 1'b0;
    else if (wr_gain && gain_pending)
      dropped <= 1'b1;
    else if (wr_status && write_data[`VBOF_STS_DROPPED])
      dropped <= 1'b0;
  end

  // gain readback copy and pending gain word
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `VBOF_BAND_CHANNELS; i++)
        gain_copy[i] <= `VBOF_RST_GAIN;
      gain_pending <= 1'b0;
      gain_hold    <= '0;
    end else begin
      if (gain_take) begin
        gain_copy[gain_idx] <= write_data[GW-1:0]; // R15
        gain_hold           <= {1'b1, gain_idx, write_data[GW-1:0]};
      end
      gain_pending <= gain_take || (gain_pending && !send_gain);
    end
  end

  // acknowledge synchroniser back from the output domain
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_toggle;
      ack_s2 <= ack_s1;
    end
  end

  // word launch toward the output clock domain
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      xfer_hold <= '0;
      xfer_req  <= 1'b0;
      sent_cfg  <= 3'h0;
    end else if (send_gain) begin
      xfer_hold <= gain_hold;
      xfer_req  <= !xfer_req;
    end else if (send_cfg) begin
      xfer_hold <= {1'b0, 5'h0, 5'h0, cfg_now};
      xfer_req  <= !xfer_req;
      sent_cfg  <= cfg_now;
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      read_data <= '0;
    else
      read_data <= read_strobe ? read_mux : '0;
  end

  // ---------------- output clock domain ----------------

  logic                       link_rst_s1;
  logic                       link_reset_n;
  logic                       tick_s1;
  logic                       tick_s2;
  logic                       tick_s3;
  logic                       req_s1;
  logic                       req_s2;
  logic                       req_s3;
  logic [GW-1:0]              link_gain [`VBOF_BAND_CHANNELS];
  logic [1:0]                 link_mode;
  logic                       link_test;
  logic [15:0]                pattern;

  wire        link_tick  = tick_s2 != tick_s3;
  wire        req_new    = req_s2 != req_s3;
  wire [15:0] next_pattern = link_tick ? 16'h0 : pattern + 16'h1; // R10 R11
  wire vbof_pkg::vbof_mode_e mode_now = to_mode(link_mode);

  // channel selection and requantizing per output channel
  logic [`VBOF_STREAM_W-1:0] next_stream1;
  logic [`VBOF_STREAM_W-1:0] next_stream2;
  for (genvar k = 0; k < `VBOF_CHANNELS; k++) begin : g_chan
    wire [SAMPLE_W-1:0] src1 = first_band_input[k*SAMPLE_W +: SAMPLE_W]; // R1 R2 R3
    wire [SAMPLE_W-1:0] hi1  = first_band_input[(k+`VBOF_CHANNELS)*SAMPLE_W +: SAMPLE_W];
    wire [SAMPLE_W-1:0] lo2  = second_band_input[k*SAMPLE_W +: SAMPLE_W];
    wire [SAMPLE_W-1:0] src2 = mode_now == vbof_pkg::VBOF_MODE_ONE ? hi1 : lo2; // R1 R2 R3
    wire [1:0] q1 = quantize(src1, link_gain[k]); // R16 R5
    wire [1:0] q2 = quantize(src2, link_gain[k+`VBOF_CHANNELS]); // R16 R5
    assign next_stream1[2*k+1:2*k] = {q1[0], q1[1]}; // R4 R6
    assign next_stream2[2*k+1:2*k] = {q2[0], q2[1]}; // R4 R6
  end

  // test pattern words for each port
  wire [`VBOF_STREAM_W-1:0] pat1 = {~pattern, pattern};
  wire [`VBOF_STREAM_W-1:0] pat2 = {pattern, ~pattern};
  wire [`VBOF_STREAM_W-1:0] out1 = link_test ? pat1 : next_stream1; // R12
  wire [`VBOF_STREAM_W-1:0] out2 = link_test ? pat2 : next_stream2; // R12

  // reset release synchroniser for the output domain
  always_ff @(posedge output_clock or negedge reset_n) begin
    if (!reset_n) begin
      link_rst_s1  <= 1'b0;
      link_reset_n <= 1'b0;
    end else begin
      link_rst_s1  <= 1'b1;
      link_reset_n <= link_rst_s1;
    end
  end

  // tick toggle synchroniser and edge history
  always_ff @(posedge output_clock or negedge link_reset_n) begin
    if (!link_reset_n) begin
      tick_s1 <= 1'b0;
      tick_s2 <= 1'b0;
      tick_s3 <= 1'b0;
    end else begin
      tick_s1 <= tick_toggle;
      tick_s2 <= tick_s1;
      tick_s3 <= tick_s2;
    end
  end

  // request toggle synchroniser and edge history
  always_ff @(posedge output_clock or negedge link_reset_n) begin
    if (!link_reset_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= xfer_req;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // carried gain words land in the link copy
  always_ff @(posedge output_clock or negedge link_reset_n) begin
    if (!link_reset_n) begin
      for (int i = 0; i < `VBOF_BAND_CHANNELS; i++)
        link_gain[i] <= `VBOF_RST_GAIN;
    end else if (req_new && xfer_hold.is_gain) begin
      link_gain[xfer_hold.index] <= xfer_hold.value; // R15
    end
  end

  // carried configuration words, then acknowledge
  always_ff @(posedge output_clock or negedge link_reset_n) begin
    if (!link_reset_n) begin
      link_mode  <= `VBOF_RST_MODE;
      link_test  <= 1'b0;
      ack_toggle <= 1'b0;
    end else begin
      if (req_new && !xfer_hold.is_gain) begin
        link_mode <= xfer_hold.value[1:0]; // R13
        link_test <= xfer_hold.value[2]; // R12
      end
      ack_toggle <= req_s2;
    end
  end

  // pattern counter and registered port outputs
  always_ff @(posedge output_clock or negedge link_reset_n) begin
    if (!link_reset_n) begin
      pattern            <= 16'h0;
      first_output_port  <= '0;
      second_output_port <= '0;
    end else begin
      pattern            <= next_pattern; // R10 R11
      first_output_port  <= {out1, link_tick}; // R17 R7
      second_output_port <= {out2, link_tick}; // R17 R7
    end
  end

endmodule
`default_nettype wire

// file: hw/vbof_output_formatter_end.sv
`default_nettype none
`default_nettype wire

// file: hw/vbof_params.svh
`ifndef VBOF_PARAMS_SVH
`define VBOF_PARAMS_SVH

// register port geometry
`define VBOF_ADDR_W         8
`define VBOF_DATA_W         32

// register byte offsets
`define VBOF_OFS_CONTROL    8'h00
`define VBOF_OFS_STATUS     8'h04
`define VBOF_OFS_GAIN_BASE  8'h40
`define VBOF_OFS_GAIN_LAST  8'hbc

// control register fields
`define VBOF_CTL_MODE_LSB   0
`define VBOF_CTL_MODE_MSB   1
`define VBOF_CTL_USE_PINS   2
`define VBOF_CTL_TEST       3
`define VBOF_CTL_ARM        4

// status register fields
`define VBOF_STS_ALIGNED    0
`define VBOF_STS_ARMED      1
`define VBOF_STS_BUSY       2
`define VBOF_STS_DROPPED    3
`define VBOF_STS_MODE_LSB   4
`define VBOF_STS_MODE_MSB   5

// reset values
`define VBOF_RST_MODE       2'h0
`define VBOF_RST_GAIN       8'h20

// channel layout
`define VBOF_CHANNELS       16
`define VBOF_BAND_CHANNELS  32
`define VBOF_GAIN_W         8
`define VBOF_GAIN_IDX_W     5
`define VBOF_STREAM_W       32

// tick timing: sample rate in Hz and tick period in seconds
`define VBOF_SAMPLE_HZ      1024000000
`define VBOF_TICK_PERIOD_S  1
`define VBOF_TICK_DIV       (`VBOF_SAMPLE_HZ * `VBOF_TICK_PERIOD_S)

`endif

// file: hw/vbof_pkg.sv
`default_nettype none
package vbof_pkg;

  // channel-to-port operating modes
  typedef enum logic [1:0] {
    VBOF_MODE_ONE,
    VBOF_MODE_TWO,
    VBOF_MODE_THREE
  } vbof_mode_e;

  // one word carried across to the output clock domain
  typedef struct packed {
    logic                    is_gain;
    logic [4:0]              index;
    logic [7:0]              value;
  } vbof_xfer_s;

  // one output port: bit-streams and tick
  typedef struct packed {
    logic [31:0]             stream;
    logic                    tick;
  } vbof_port_s;

endpackage
`default_nettype wire
